//--- hdl/fpsx_pkg.sv
// Purpose: Shared constants of the floating status and exception unit
// Assumes: 16-bit processor words, octal figures written as hex here
// Notes: Exception codes are the values software sees in the cause register
package fpsx_pkg;
    // Status word bit positions
    localparam int BIT_ERR = 15;
    localparam int BIT_INHIBIT = 14;
    localparam int BIT_NEGZ_EN = 11;
    localparam int BIT_UNDER_EN = 10;
    localparam int BIT_OVER_EN = 9;
    localparam int BIT_CONV_EN = 8;
    localparam int BIT_WIDE = 7;
    localparam int BIT_LONG = 6;
    localparam int BIT_CHOP = 5;
    localparam int BIT_NEG = 3;
    localparam int BIT_ZERO = 2;
    localparam int BIT_OVER = 1;
    localparam int BIT_CARRY = 0;
    // Writable bits: all but bits 13, 12 and 4
    localparam logic [15:0] STATUS_WMASK = 16'hCFEF;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // Exception cause codes
    localparam logic [3:0] CODE_OPCODE = 4'h2;
    localparam logic [3:0] CODE_DIVZERO = 4'h4;
    localparam logic [3:0] CODE_CONVERT = 4'h6;
    localparam logic [3:0] CODE_OVERFLOW = 4'h8;
    localparam logic [3:0] CODE_UNDERFLOW = 4'hA;
    localparam logic [3:0] CODE_NEGZERO = 4'hC;
    localparam logic [3:0] CODE_RESET = 4'h0;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    // Single trap vector, 244 octal
    localparam logic [15:0] TRAP_VECTOR = 16'h00A4;
    // Exponent correction, 400 octal, applied mod 2**8 only to wrapped exponent
    localparam logic [8:0] EXP_WRAP = 9'h100;
    // Address steps: 4 single, 10 octal double
    localparam logic [15:0] STEP_SINGLE = 16'h0004;
    localparam logic [15:0] STEP_DOUBLE = 16'h0008;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [2:0] MODE_ACC = 3'h0;
    localparam logic [2:0] MODE_AUTOINC = 3'h2;
    localparam logic [2:0] MODE_AUTOINC_DEF = 3'h3;
    localparam logic [2:0] MODE_AUTODEC = 3'h4;
    localparam logic [2:0] MODE_AUTODEC_DEF = 3'h5;
    localparam logic [2:0] ACC_MAX_REG = 3'h5;
    localparam logic [2:0] ACC_MAX_MEM = 3'h3;
    localparam int SHORT_INT_BITS = 16;
    localparam int LONG_INT_BITS = 32;
endpackage

//--- hdl/fpsx_addr_if.sv
// Purpose: Carrier between the top and the operand address decoder
// Assumes: One clock, same domain
// Notes: Purely combinational request and answer
`timescale 1ns/1ps
interface fpsx_addr_if;
    logic [2:0] mode;
    logic [2:0] accSel;
    logic [15:0] regValue;
    logic wideMode;
    logic isAcc;
    logic illegalAcc;
    logic [15:0] effAddr;
    logic [15:0] regUpdate;
    logic regWrite;
    modport top (output mode, accSel, regValue, wideMode,
        input isAcc, illegalAcc, effAddr, regUpdate, regWrite);
    modport dec (input mode, accSel, regValue, wideMode,
        output isAcc, illegalAcc, effAddr, regUpdate, regWrite);
endinterface

//--- hdl/fpsx_addr_decode.sv
// Purpose: Decodes floating operand addressing mode and accumulator legality
// Assumes: Deferred and indexed modes resolved by the core; this gives the pointer
// Notes: Combinational only
`timescale 1ns/1ps
module fpsx_addr_decode (
    fpsx_addr_if.dec bus
);
    logic [15:0] step;
    always_comb begin
        step = bus.wideMode ? fpsx_pkg::STEP_DOUBLE : fpsx_pkg::STEP_SINGLE;
        bus.isAcc = (bus.mode == fpsx_pkg::MODE_ACC);
        // Mode 0 allows AC0..AC5, other modes AC0..AC3
        if (bus.isAcc) begin
            bus.illegalAcc = bus.accSel > fpsx_pkg::ACC_MAX_REG;
        end else begin
            bus.illegalAcc = bus.accSel > fpsx_pkg::ACC_MAX_MEM;
        end
        bus.effAddr = bus.regValue;
        bus.regUpdate = bus.regValue;
        bus.regWrite = 1'b0;
        unique case (bus.mode)
            fpsx_pkg::MODE_AUTOINC: begin
                bus.regUpdate = bus.regValue + step;
                bus.regWrite = 1'b1;
            end
            fpsx_pkg::MODE_AUTOINC_DEF: begin
                bus.regUpdate = bus.regValue + fpsx_pkg::STEP_WORD;
                bus.regWrite = 1'b1;
            end
            fpsx_pkg::MODE_AUTODEC: begin
                bus.regUpdate = bus.regValue - step;
                bus.effAddr = bus.regValue - step;
                bus.regWrite = 1'b1;
            end
            fpsx_pkg::MODE_AUTODEC_DEF: begin
                bus.regUpdate = bus.regValue - fpsx_pkg::STEP_WORD;
                bus.effAddr = bus.regValue - fpsx_pkg::STEP_WORD;
                bus.regWrite = 1'b1;
            end
            default: begin
            end
        endcase
    end
endmodule

//--- hdl/fpsx_result_fix.sv
// Purpose: Adjusts a result exponent and sign for overflow, underflow, conversion
// Assumes: Datapath supplies the 9-bit true biased exponent before wrapping
// Notes: Combinational only
`timescale 1ns/1ps
module fpsx_result_fix (
    input wire logic overflow,
    input wire logic underflow,
    input wire logic convFail,
    input wire logic overEn,
    input wire logic underEn,
    input wire logic [63:0] rawResult,
    input wire logic [8:0] rawExp,
    output logic [63:0] fixedResult,
    output logic forcedZero
);
    logic [8:0] wrapped;
    always_comb begin
        wrapped = rawExp;
        fixedResult = rawResult;
        forcedZero = 1'b0;
        if (convFail) begin
            fixedResult = '0;
            forcedZero = 1'b1;
        end else if (overflow && !overEn) begin
            fixedResult = '0;
            forcedZero = 1'b1;
        end else if (underflow && !underEn) begin
            fixedResult = '0;
            forcedZero = 1'b1;
        end else if (overflow || underflow) begin
            // Keep the low eight exponent bits: off by 400 octal, zero exact
            wrapped = rawExp & ~fpsx_pkg::EXP_WRAP;
            fixedResult = {rawResult[63], wrapped[7:0], rawResult[54:0]};
        end
    end
endmodule

//--- hdl/fpsx_status_unit.sv
// Purpose: Floating status word, exception cause and address, trap request
// Assumes: Core pulses opDone with event flags for each floating operation
// Notes: Results pass through with memory word order most significant first
`timescale 1ns/1ps
module fpsx_status_unit (
    input wire logic clock,
    input wire logic srst,
    input wire logic loadStatus,
    input wire logic [15:0] loadValue,
    input wire logic opDone,
    input wire logic [15:0] instrAddr,
    input wire logic illegalOpcode,
    input wire logic divideByZero,
    input wire logic overflow,
    input wire logic underflow,
    input wire logic isConversion,
    input wire logic [32:0] convMagnitudeBits,
    input wire logic memOperandNegZero,
    input wire logic negZeroCheckOp,
    input wire logic carryOut,
    input wire logic [63:0] rawResult,
    input wire logic [8:0] rawExp,
    input wire logic [2:0] operandMode,
    input wire logic [2:0] accSel,
    input wire logic [15:0] operandReg,
    output logic [15:0] realStatusWord,
    output logic [3:0] exceptionCauseCode,
    output logic [15:0] exceptionInstrAddress,
    output logic trapRequest,
    output logic [15:0] trapVector,
    output logic negZeroPreTrap,
    output logic [63:0] resultOut,
    output logic [15:0] memWord0,
    output logic [15:0] memWord1,
    output logic [15:0] memWord2,
    output logic [15:0] memWord3,
    output logic wideRealMode,
    output logic longIntegerMode,
    output logic chopMode,
    output logic accOperand,
    output logic [15:0] operandAddr,
    output logic [15:0] operandRegNext,
    output logic operandRegWrite
);
    // =========================================================
    // State
    logic [15:0] status_reg;
    logic [3:0] code_reg;
    logic [15:0] addr_reg;
    logic trap_reg;
    logic [63:0] result_reg;

    // =========================================================
    // Operand addressing
    fpsx_addr_if addrBus ();
    assign addrBus.mode = operandMode;
    assign addrBus.accSel = accSel;
    assign addrBus.regValue = operandReg;
    assign addrBus.wideMode = status_reg[fpsx_pkg::BIT_WIDE];
    fpsx_addr_decode u_dec (
        .bus(addrBus)
    );
    assign accOperand = addrBus.isAcc;
    assign operandAddr = addrBus.effAddr;
    assign operandRegNext = addrBus.regUpdate;
    assign operandRegWrite = addrBus.regWrite;

    // =========================================================
    // Exception detection
    logic opErr;
    logic convFail;
    logic negZeroEv;
    logic overEv;
    logic underEv;
    logic convEv;
    logic qualify;
    logic [3:0] causeNext;
    logic [32:0] shortLimitMask;
    logic [32:0] longLimitMask;

    assign opErr = illegalOpcode || addrBus.illegalAcc;
    // Magnitude bits 15 and up (31 and up in long mode) mean the integer does not fit
    assign shortLimitMask = {{(33 - fpsx_pkg::SHORT_INT_BITS + 1){1'b1}},
        {(fpsx_pkg::SHORT_INT_BITS - 1){1'b0}}};
    assign longLimitMask = {{(33 - fpsx_pkg::LONG_INT_BITS + 1){1'b1}},
        {(fpsx_pkg::LONG_INT_BITS - 1){1'b0}}};
    assign convFail = isConversion && |(convMagnitudeBits &
        (status_reg[fpsx_pkg::BIT_LONG] ? longLimitMask : shortLimitMask));
    // Accumulator operands never raise the negative-zero trap
    assign negZeroEv = memOperandNegZero && negZeroCheckOp && !addrBus.isAcc
        && status_reg[fpsx_pkg::BIT_NEGZ_EN];
    assign overEv = overflow && status_reg[fpsx_pkg::BIT_OVER_EN];
    assign underEv = underflow && status_reg[fpsx_pkg::BIT_UNDER_EN];
    assign convEv = convFail && status_reg[fpsx_pkg::BIT_CONV_EN];
    assign qualify = opDone && (opErr || divideByZero || negZeroEv || overEv
        || underEv || convEv);

    always_comb begin
        if (opErr) begin
            causeNext = fpsx_pkg::CODE_OPCODE;
        end else if (negZeroEv) begin
            causeNext = fpsx_pkg::CODE_NEGZERO;
        end else if (divideByZero) begin
            causeNext = fpsx_pkg::CODE_DIVZERO;
        end else if (convEv) begin
            causeNext = fpsx_pkg::CODE_CONVERT;
        end else if (overEv) begin
            causeNext = fpsx_pkg::CODE_OVERFLOW;
        end else begin
            causeNext = fpsx_pkg::CODE_UNDERFLOW;
        end
    end

    // =========================================================
    // Result adjustment
    logic [63:0] fixedResult;
    logic forcedZero;
    fpsx_result_fix u_fix (
        .overflow(overflow),
        .underflow(underflow),
        .convFail(convFail),
        .overEn(status_reg[fpsx_pkg::BIT_OVER_EN]),
        .underEn(status_reg[fpsx_pkg::BIT_UNDER_EN]),
        .rawResult(rawResult),
        .rawExp(rawExp),
        .fixedResult(fixedResult),
        .forcedZero(forcedZero)
    );

    // =========================================================
    // Status word
    logic [15:0] status_next;
    always_comb begin
        status_next = status_reg;
        if (loadStatus) begin
            status_next = loadValue & fpsx_pkg::STATUS_WMASK;
        end else if (opDone && !opErr && !negZeroEv) begin
            status_next[fpsx_pkg::BIT_NEG] = fixedResult[63];
            status_next[fpsx_pkg::BIT_ZERO] = forcedZero || (rawExp[7:0] == 8'h00);
            status_next[fpsx_pkg::BIT_OVER] = overflow;
            status_next[fpsx_pkg::BIT_CARRY] = carryOut && isConversion
                && status_reg[fpsx_pkg::BIT_WIDE];
        end
        // Hardware set wins over a same-cycle load
        if (qualify) begin
            status_next[fpsx_pkg::BIT_ERR] = 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            status_reg <= fpsx_pkg::STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // =========================================================
    // Exception cause and address
    always_ff @(posedge clock) begin
        if (srst) begin
            code_reg <= fpsx_pkg::CODE_RESET;
            addr_reg <= fpsx_pkg::ADDR_RESET;
        end else if (qualify) begin
            code_reg <= causeNext;
            addr_reg <= instrAddr;
        end
    end

    // =========================================================
    // Trap request and result
    always_ff @(posedge clock) begin
        if (srst) begin
            trap_reg <= 1'b0;
        end else begin
            trap_reg <= qualify && !status_reg[fpsx_pkg::BIT_INHIBIT];
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            result_reg <= '0;
        end else if (opDone && !opErr && !negZeroEv) begin
            result_reg <= fixedResult;
        end
    end

    assign realStatusWord = status_reg;
    assign exceptionCauseCode = code_reg;
    assign exceptionInstrAddress = addr_reg;
    assign trapRequest = trap_reg;
    assign trapVector = fpsx_pkg::TRAP_VECTOR;
    assign negZeroPreTrap = negZeroEv;
    assign resultOut = result_reg;
    assign memWord0 = result_reg[63:48];
    assign memWord1 = result_reg[47:32];
    assign memWord2 = result_reg[31:16];
    assign memWord3 = result_reg[15:0];
    assign wideRealMode = status_reg[fpsx_pkg::BIT_WIDE];
    assign longIntegerMode = status_reg[fpsx_pkg::BIT_LONG];
    assign chopMode = status_reg[fpsx_pkg::BIT_CHOP];

    // =========================================================
    // Checks
    chk_err_sticky: assert property (@(posedge clock) disable iff (srst)
        status_reg[fpsx_pkg::BIT_ERR] && !loadStatus |=> status_reg[fpsx_pkg::BIT_ERR])
        else $error("error flag cleared without load");
    chk_err_set: assert property (@(posedge clock) disable iff (srst)
        qualify |=> status_reg[fpsx_pkg::BIT_ERR])
        else $error("error flag not set");
    chk_inhibit_trap: assert property (@(posedge clock) disable iff (srst)
        status_reg[fpsx_pkg::BIT_INHIBIT] |=> !trapRequest)
        else $error("trap while inhibited");
    chk_reserved_zero: assert property (@(posedge clock) disable iff (srst)
        (status_reg & ~fpsx_pkg::STATUS_WMASK) == 16'h0000)
        else $error("reserved bit set");
    chk_addr_hold: assert property (@(posedge clock) disable iff (srst)
        !qualify |=> $stable(exceptionInstrAddress) && $stable(exceptionCauseCode))
        else $error("exception registers changed");
    chk_addr_capture: assert property (@(posedge clock) disable iff (srst)
        qualify |=> exceptionInstrAddress == $past(instrAddr))
        else $error("address not captured");
    chk_acc_trap: assert property (@(posedge clock) disable iff (srst)
        opDone && addrBus.isAcc && accSel > fpsx_pkg::ACC_MAX_REG
        |=> exceptionCauseCode == fpsx_pkg::CODE_OPCODE)
        else $error("bad accumulator not trapped");
    chk_over_zero: assert property (@(posedge clock) disable iff (srst)
        opDone && overflow && !status_reg[fpsx_pkg::BIT_OVER_EN] && !opErr && !negZeroEv
        |=> resultOut == 64'h0000000000000000 && !trapRequest ##0 1)
        else $error("overflow result not zero");
    chk_conv_zero: assert property (@(posedge clock) disable iff (srst)
        opDone && convFail && !opErr && !negZeroEv
        |=> resultOut == 64'h0000000000000000)
        else $error("failed conversion result not zero");
    chk_under_zero: assert property (@(posedge clock) disable iff (srst)
        opDone && underflow && !overflow && !convFail && !opErr && !negZeroEv
        && !status_reg[fpsx_pkg::BIT_UNDER_EN]
        |=> resultOut == 64'h0000000000000000)
        else $error("untrapped underflow result not zero");
    cov_trap: cover property (@(posedge clock) disable iff (srst) trapRequest);
    cov_inhibit: cover property (@(posedge clock) disable iff (srst)
        qualify && status_reg[fpsx_pkg::BIT_INHIBIT]);
    cov_clear: cover property (@(posedge clock) disable iff (srst)
        status_reg[fpsx_pkg::BIT_ERR] ##1 !status_reg[fpsx_pkg::BIT_ERR]);
    cov_negzero: cover property (@(posedge clock) disable iff (srst)
        opDone && negZeroEv);
    cov_wrap: cover property (@(posedge clock) disable iff (srst)
        opDone && (overEv || underEv));
endmodule

//--- tb/fpsx_core_model.sv
// Purpose: Host core model that issues floating operations and status loads
// Assumes: Inputs change on the falling clock edge and hold for one cycle
// Notes: Data lines carry inverted values between requests
`timescale 1ns/1ps
module fpsx_core_model (
    input wire logic clock,
    output logic loadStatus,
    output logic [15:0] loadValue,
    output logic opDone,
    output logic [15:0] instrAddr,
    output logic illegalOpcode,
    output logic divideByZero,
    output logic overflow,
    output logic underflow,
    output logic isConversion,
    output logic [32:0] convMagnitudeBits,
    output logic memOperandNegZero,
    output logic negZeroCheckOp,
    output logic carryOut,
    output logic [63:0] rawResult,
    output logic [8:0] rawExp,
    output logic [2:0] operandMode,
    output logic [2:0] accSel,
    output logic [15:0] operandReg
);
    // ==========================================
    // Idle state
    initial begin
        {loadStatus, opDone, illegalOpcode, divideByZero, overflow, underflow} = 6'h00;
        {isConversion, memOperandNegZero, negZeroCheckOp, carryOut} = 4'h0;
        {loadValue, instrAddr, operandReg} = 48'h0;
        {convMagnitudeBits, rawExp, operandMode, accSel} = 48'h0;
        rawResult = 64'h0;
    end

    // ==========================================
    // Requests
    task automatic loadWord(input logic [15:0] v);
        @(negedge clock);
        loadValue = v;
        loadStatus = 1'b1;
        @(negedge clock);
        loadStatus = 1'b0;
        loadValue = ~v;
    endtask

    task automatic issue(input logic [15:0] a, input logic [6:0] f, input logic [32:0] m,
        input logic [63:0] r, input logic [8:0] e, input logic [2:0] md, input logic [2:0] ac);
        @(negedge clock);
        instrAddr = a;
        {illegalOpcode, divideByZero, overflow, underflow} = f[6:3];
        {isConversion, memOperandNegZero, carryOut} = f[2:0];
        negZeroCheckOp = f[1];
        {convMagnitudeBits, rawResult, rawExp} = {m, r, e};
        {operandMode, accSel} = {md, ac};
        opDone = 1'b1;
        @(negedge clock);
        opDone = 1'b0;
        {illegalOpcode, divideByZero, overflow, underflow} = 4'h0;
        {isConversion, memOperandNegZero, negZeroCheckOp, carryOut} = 4'h0;
        {instrAddr, convMagnitudeBits, rawResult, rawExp} = ~{a, m, r, e};
    endtask

    task automatic point(input logic [2:0] md, input logic [2:0] ac, input logic [15:0] rg);
        @(negedge clock);
        {operandMode, accSel, operandReg} = {md, ac, rg};
    endtask
endmodule

//--- tb/fp_status_exception_unit_tb_top.sv
// Purpose: Self-checking bench of the floating status and exception unit
// Assumes: Core model drives requests on the falling edge
// Notes: Expected results queue up; a monitor checks them a cycle after each request
`timescale 1ns/1ps
module fp_status_exception_unit_tb_top;
    typedef struct packed {
        logic [15:0] st;
        logic [15:0] mask;
        logic [3:0] code;
        logic [15:0] addr;
        logic trap;
        logic chk;
        logic [63:0] res;
    } fpsx_note_type;
    logic clock, srst, loadStatus, opDone, illegalOpcode, divideByZero, overflow, underflow;
    logic isConversion, memOperandNegZero, negZeroCheckOp, carryOut, trapRequest, negZeroPreTrap;
    logic wideRealMode, longIntegerMode, chopMode, accOperand, operandRegWrite, tookOp, expNz;
    logic [15:0] loadValue, instrAddr, operandReg, realStatusWord, exceptionInstrAddress;
    logic [15:0] trapVector, memWord0, memWord1, memWord2, memWord3, operandAddr, operandRegNext;
    logic [15:0] expSt, expAddr, lfsrState, rv, step;
    logic [3:0] exceptionCauseCode, expCode;
    logic [32:0] convMagnitudeBits;
    logic [63:0] rawResult, resultOut;
    logic [8:0] rawExp;
    logic [2:0] operandMode, accSel;
    fpsx_note_type notes[$];
    fpsx_note_type cur;
    int badCount, compares, cycles;

    fpsx_status_unit u_dut (
        .clock(clock), .srst(srst), .loadStatus(loadStatus), .loadValue(loadValue),
        .opDone(opDone), .instrAddr(instrAddr), .illegalOpcode(illegalOpcode),
        .divideByZero(divideByZero), .overflow(overflow), .underflow(underflow),
        .isConversion(isConversion), .convMagnitudeBits(convMagnitudeBits),
        .memOperandNegZero(memOperandNegZero), .negZeroCheckOp(negZeroCheckOp),
        .carryOut(carryOut), .rawResult(rawResult), .rawExp(rawExp),
        .operandMode(operandMode), .accSel(accSel), .operandReg(operandReg),
        .realStatusWord(realStatusWord), .exceptionCauseCode(exceptionCauseCode),
        .exceptionInstrAddress(exceptionInstrAddress), .trapRequest(trapRequest),
        .trapVector(trapVector), .negZeroPreTrap(negZeroPreTrap), .resultOut(resultOut),
        .memWord0(memWord0), .memWord1(memWord1), .memWord2(memWord2), .memWord3(memWord3),
        .wideRealMode(wideRealMode), .longIntegerMode(longIntegerMode), .chopMode(chopMode),
        .accOperand(accOperand), .operandAddr(operandAddr), .operandRegNext(operandRegNext),
        .operandRegWrite(operandRegWrite)
    );

    fpsx_core_model u_core (
        .clock(clock), .loadStatus(loadStatus), .loadValue(loadValue), .opDone(opDone),
        .instrAddr(instrAddr), .illegalOpcode(illegalOpcode), .divideByZero(divideByZero),
        .overflow(overflow), .underflow(underflow), .isConversion(isConversion),
        .convMagnitudeBits(convMagnitudeBits), .memOperandNegZero(memOperandNegZero),
        .negZeroCheckOp(negZeroCheckOp), .carryOut(carryOut), .rawResult(rawResult),
        .rawExp(rawExp), .operandMode(operandMode), .accSel(accSel), .operandReg(operandReg)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ==========================================
    // Helpers
    function automatic logic [15:0] rnd();
        lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
        return lfsrState;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] want);
        compares++;
        if (got !== want) begin
            badCount++;
            $display("FAIL t=%0t got %h exp %h", $time, got, want);
        end
    endtask

    task automatic reportAndStop();
        $display("Compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic ld(input logic [15:0] v);
        fpsx_note_type n;
        expSt = v & 16'hCFEF;
        n = '{expSt, 16'hFFFF, expCode, expAddr, 1'b0, 1'b0, 64'h0};
        notes.push_back(n);
        u_core.loadWord(v);
    endtask

    // Flags: illegal, divide, overflow, underflow, conversion, negative zero, carry
    task automatic op(input logic [6:0] f, input logic [32:0] m, input logic [2:0] md,
        input logic [2:0] ac);
        fpsx_note_type n;
        logic [15:0] a;
        logic [63:0] r, er;
        logic [8:0] e;
        logic [3:0] c;
        logic ill, nz, cf, tr, ck;
        a = rnd();
        r = {rnd(), rnd(), rnd(), rnd()};
        r[62] = 1'b1;
        ill = f[6] | (md == 3'h0 ? ac > 3'h5 : ac > 3'h3);
        nz = f[1] & expSt[11] & (md != 3'h0);
        expNz = nz;
        cf = f[2] & (expSt[6] ? |m[32:31] : |m[32:15]);
        c = ill ? 4'h2 : nz ? 4'hC : f[5] ? 4'h4 : (cf & expSt[8]) ? 4'h6
            : (f[4] & expSt[9]) ? 4'h8 : (f[3] & expSt[10]) ? 4'hA : 4'h0;
        e = (f[4] | f[3]) ? {1'b1, ~r[62:55]} : {1'b0, r[62:55]};
        er = r;
        if (f[4] | f[3]) er = (f[4] ? expSt[9] : expSt[10]) ? {r[63], ~r[62:55], r[54:0]} : 64'h0;
        if (cf) er = 64'h0;
        tr = 1'b0;
        if (c != 4'h0) begin
            expSt[15] = 1'b1;
            expCode = c;
            expAddr = a;
            tr = !expSt[14];
        end
        ck = !(ill | nz | f[5] | (f[2] & !cf));
        if (ck) expSt[3:0] = {er[63], er[62:55] == 8'h00, f[4], 1'b0};
        n = '{expSt, (ck & !f[2]) ? 16'hFFFF : 16'hFFF0, expCode, expAddr, tr, ck, er};
        notes.push_back(n);
        u_core.issue(a, f, m, r, e, md, ac);
    endtask

    // ==========================================
    // Monitor and timeout
    always @(posedge clock) tookOp <= !srst & (opDone | loadStatus);

    // Pre-execution trap flag stands only while the operation is offered
    always @(posedge clock) begin
        if (opDone && !srst) chk(64'(negZeroPreTrap), 64'(expNz));
    end

    always @(negedge clock) begin
        if (tookOp) begin
            if (notes.size() == 0) chk(64'h0, 64'h1);
            else begin
                cur = notes.pop_front();
                chk(64'(realStatusWord & cur.mask), 64'(cur.st & cur.mask));
                chk(64'({wideRealMode, longIntegerMode, chopMode}), 64'(cur.st[7:5]));
                chk(64'(exceptionCauseCode), 64'(cur.code));
                chk(64'(exceptionInstrAddress), 64'(cur.addr));
                chk(64'(trapRequest), 64'(cur.trap));
                if (cur.chk) begin
                    chk(resultOut, cur.res);
                    chk({memWord0, memWord1, memWord2, memWord3}, cur.res);
                end
            end
        end else if (!srst) chk(64'(trapRequest), 64'h0);
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            badCount++;
            reportAndStop();
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        srst = 1'b1;
        lfsrState = 16'h02C8;
        {expSt, expAddr, expCode} = 36'h0;
        repeat (8) @(negedge clock);
        srst = 1'b0;
        chk(64'({realStatusWord, exceptionCauseCode, exceptionInstrAddress}), 64'h0);
        chk(64'(trapVector), 64'h00A4);
        ld(16'hFFFF);
        op(7'h20, 33'h0, 3'h1, 3'h0);
        ld(16'h0000);
        ld(16'h0F00);
        op(7'h40, 33'h0, 3'h1, 3'h0);
        op(7'h00, 33'h0, 3'h0, 3'h6);
        op(7'h00, 33'h0, 3'h0, 3'h5);
        op(7'h00, 33'h0, 3'h2, 3'h4);
        op(7'h02, 33'h0, 3'h1, 3'h0);
        op(7'h02, 33'h0, 3'h0, 3'h0);
        op(7'h10, 33'h0, 3'h1, 3'h0);
        op(7'h08, 33'h0, 3'h1, 3'h0);
        op(7'h04, 33'h000008000, 3'h1, 3'h0);
        op(7'h04, 33'h000004000, 3'h1, 3'h0);
        op(7'h00, 33'h0, 3'h1, 3'h0);
        ld(16'h0040);
        op(7'h04, 33'h080000000, 3'h1, 3'h0);
        op(7'h04, 33'h040000000, 3'h1, 3'h0);
        op(7'h10, 33'h0, 3'h1, 3'h0);
        op(7'h08, 33'h0, 3'h1, 3'h0);
        op(7'h20, 33'h0, 3'h1, 3'h0);
        for (int i = 0; i < 24; i++) begin
            ld(rnd());
            rv = rnd();
            op(7'(1 << (rv[2:0] % 6 + 1)), {rv, rnd(), 1'b0}, rv[5:3], rv[8:6]);
        end
        for (int w = 0; w < 2; w++) begin
            ld(w ? 16'h0080 : 16'h0000);
            for (int md = 0; md < 6; md++) begin
                rv = rnd();
                u_core.point(3'(md), 3'h0, rv);
                #1;
                step = (md == 3 || md == 5) ? 16'h0002 : (w ? 16'h0008 : 16'h0004);
                chk(64'(accOperand), 64'(md == 0));
                chk(64'(operandRegWrite), 64'(md > 1));
                if (md > 1) chk(64'(operandAddr), 64'(md < 4 ? rv : rv - step));
                if (md > 1) chk(64'(operandRegNext), 64'(md < 4 ? rv + step : rv - step));
            end
        end
        repeat (3) @(negedge clock);
        chk(64'(notes.size()), 64'h0);
        reportAndStop();
    end
endmodule
